// ===== rtl/wwdt_pkg.sv
// Purpose: shared constants and types of the windowed watchdog timer
// Assumes: APB with 32-bit data, one clock of 125 MHz
// Notes: printed offsets are register indices; byte address is index times four

package wwdt_pkg;

	// ***********************
	// Register map
	// ***********************
	localparam logic [7:0] IDX_DOG_CONTROL = 8'h2a;
	localparam logic [7:0] IDX_DOG_CONFIG = 8'h2b;
	localparam logic [7:0] IDX_DOG_STATUS = 8'h2c;
	localparam logic [11:0] ADDR_DOG_CONTROL = {2'h0, IDX_DOG_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_DOG_CONFIG = {2'h0, IDX_DOG_CONFIG, 2'h0};
	localparam logic [11:0] ADDR_DOG_STATUS = {2'h0, IDX_DOG_STATUS, 2'h0};

	// ***********************
	// Fields and reset values
	// ***********************
	localparam logic [7:0] DOG_CONTROL_RESET = 8'h7f;
	localparam logic [4:0] DOG_CONFIG_RESET = 5'h00;
	localparam int ACT_BIT = 7;
	localparam int TOP_BIT = 6;
	localparam int CFG_TB_LO = 0;
	localparam int CFG_IRQ_EN = 2;
	localparam int CFG_HALT_RST = 3;
	localparam int CFG_WAKE_LONG = 4;
	localparam logic [6:0] COUNT_ROLL_FROM = 7'h40;

	// ***********************
	// Timing
	// ***********************
	localparam int unsigned STEP_OSC = 16384;
	localparam int unsigned SUB_UNIT = 64;
	localparam int unsigned SHORT_BASE = 192;
	localparam int unsigned PHASE_INC = 4;
	localparam logic [12:0] WAKE_SHORT = 13'h0100;
	localparam logic [12:0] WAKE_LONG = 13'h1000;
	localparam logic [5:0] TB_MSB [4] = '{6'h04, 6'h08, 6'h14, 6'h31};
	localparam logic [5:0] TB_LSB [4] = '{6'h3b, 6'h35, 6'h23, 6'h36};

	// ***********************
	// Types
	// ***********************
	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_ACTIVE_HALT = 2'b01,
		MODE_HALT = 2'b10,
		MODE_WAKE_WAIT = 2'b11
	} wwdt_mode_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} wwdt_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} wwdt_apb_rsp_t;

endpackage

// ===== rtl/wwdt_top.sv
// Purpose: windowed watchdog timer with APB register access
// Assumes: halt and interrupt strobes come from logic on clk_sys
// Notes: one clk_sys cycle stands for one oscillator period
//
// The APB register port was left to the implementer.

`timescale 1ns/1ps

module wwdt_top
	import wwdt_pkg::*;
#(
	parameter int unsigned STEP_CYCLES = STEP_OSC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Register bus
	input wire wwdt_pkg::wwdt_apb_req_t apbReq,
	output wwdt_pkg::wwdt_apb_rsp_t apbRsp,
	// Processor events
	input wire logic haltExec,
	input wire logic extIrq,
	input wire logic oscIrq,
	// Option byte
	input wire logic hwDogOption,
	// Reset request and mode
	output logic dogReset,
	output logic [1:0] dogMode
);
	import wwdt_pkg::*;

	// ***********************
	// Register layout
	// ***********************
	// Control word, index 2Ah, read and write:
	//   bit 7: activation, sticky until reset
	//   bits 6:0: down-counter, top bit arms the reset
	// Config word, index 2Bh, read and write:
	//   bits 1:0: time base selection
	//   bit 2: rtc interrupt enable
	//   bit 3: halt reset option
	//   bit 4: long wake delay
	// Status word, index 2Ch, read only:
	//   bits 1:0: current mode
	//   bit 2: latched hardware option
	// Unmapped addresses answer with pslverr, writes dropped
	// Upper data bits read zero; writes ignore them
	// Zero wait states: answer prepared in setup
	// Read data taken in setup, may lag a tick by a cycle

	// ***********************
	// Timing
	// ***********************
	// One clk_sys cycle per oscillator period
	// Normal step: STEP_CYCLES clocks per decrement
	// Short step: (64 - LSB) * 64 clocks fewer
	// Phase grows by four each step; reaching MSB
	// Makes the next step short, keeping the time base phase
	// Time base selection read live at every tick
	// Change of time base takes effect at the next tick
	// Control write clears the phase, prescaler runs on
	// Hence timeout spread of up to one step
	// Wake delay: 256 or 4096 clocks in wake wait
	// Every reset starts in wake wait, short delay
	// Limitation: STEP_CYCLES of 1856 or less wraps short steps

	// ***********************
	// Modes
	// ***********************
	// Run: prescaler and counter live, halt decoded
	// Active halt: all frozen, either interrupt resumes
	// Halt: frozen after one decrement, only a control write can reset
	// Wake wait: settling delay, then run
	// Slow and wait never reach this block
	// Mode codes visible on dogMode and status

	// ***********************
	// Hazards
	// ***********************
	// Write and tick together: written count wins
	// Tick at 40h with a write: reset still fires
	// Halt and tick together: halt decides the count
	// Option byte caught once; a change needs a reset
	// Software reset request ignores the current mode
	// Reset request lasts one cycle; stretched outside
	// Wake counter holds its value outside wake wait
	// Count wraps 00h to 7Fh, harmless while disabled
	// Status reads give a mode that may change next cycle

	// ***********************
	// Helpers
	// ***********************

	// Step length after a tick; short steps keep the prescaler in phase
	function automatic logic [15:0] stepLength(input logic isShort, input logic [5:0] lsb);
		logic [15:0] shortLen;
		shortLen = 16'(STEP_CYCLES - (SUB_UNIT - 32'(lsb)) * SUB_UNIT);
		stepLength = isShort ? shortLen - 16'h0001 : 16'(STEP_CYCLES - 1);
	endfunction

	// Wake delay as a down-count
	function automatic logic [12:0] wakeLoad(input logic longDelay);
		wakeLoad = (longDelay ? WAKE_LONG : WAKE_SHORT) - 13'h0001;
	endfunction

	// Register select, shared by the write decodes
	function automatic logic regHit(input logic [11:0] addr, input logic [11:0] base);
		regHit = (addr == base);
	endfunction

	// One counter decrement; 00h wraps to 7Fh
	function automatic logic [6:0] countDown(input logic [6:0] value);
		countDown = value - 7'h01;
	endfunction

	// ***********************
	// State
	// ***********************
	// Architectural state
	logic actBit;
	logic [6:0] count;
	logic [4:0] cfg;
	// Prescaler, phase and wake timing
	logic [15:0] preCnt;
	logic [5:0] phase;
	logic [12:0] wakeCnt;
	wwdt_mode_t mode;
	logic hwOpt;
	logic hwSeen;
	// Next values
	logic next_actBit;
	logic [6:0] next_count;
	logic [4:0] next_cfg;
	logic [15:0] next_preCnt;
	logic [5:0] next_phase;
	logic [12:0] next_wakeCnt;
	wwdt_mode_t next_mode;
	logic next_dogReset;
	logic next_hwOpt;
	logic next_hwSeen;
	wwdt_apb_rsp_t next_apbRsp;

	// Bus decode
	logic accessDone;
	logic wrCtrl;
	logic wrCfg;
	logic [7:0] wdata;
	// Derived signals
	logic [1:0] tbSel;
	logic [5:0] msb;
	logic [5:0] lsb;
	logic [6:0] phaseSum;
	logic shortNext;
	logic active;
	logic tick;

	assign accessDone = apbReq.psel & apbReq.penable & apbRsp.pready;
	assign wdata = apbReq.pwdata[7:0];
	assign wrCtrl = accessDone & apbReq.pwrite & regHit(apbReq.paddr, ADDR_DOG_CONTROL);
	assign wrCfg = accessDone & apbReq.pwrite & regHit(apbReq.paddr, ADDR_DOG_CONFIG);
	assign tbSel = cfg[CFG_TB_LO +: 2];
	assign msb = TB_MSB[tbSel];
	assign lsb = TB_LSB[tbSel];
	// Every fourth of MSB steps, one is short
	assign phaseSum = {1'b0, phase} + 7'(PHASE_INC);
	assign shortNext = phaseSum >= {1'b0, msb};
	assign active = actBit | hwOpt;
	// Only normal run counts; slow and wait do not reach this block
	assign tick = (mode == MODE_RUN) && (preCnt == 16'h0000);

	// ***********************
	// Watchdog core
	// ***********************

	// Next state of counter, prescaler, mode and reset request
	always_comb begin
		next_actBit = actBit;
		next_count = count;
		next_cfg = cfg;
		next_preCnt = preCnt;
		next_phase = phase;
		next_wakeCnt = wakeCnt;
		next_mode = mode;
		next_dogReset = 1'b0;
		next_hwOpt = hwOpt;
		next_hwSeen = 1'b1;
		// Option byte is caught once after reset release
		if (!hwSeen) begin
			next_hwOpt = hwDogOption;
		end
		// Config write, taken in any mode
		if (wrCfg) begin
			next_cfg = wdata[4:0];
		end
		// Per-mode behaviour
		unique case (mode)
			// Run: count, check roll-over, decode halt
			MODE_RUN: begin
				// Free-running prescaler and counter, even when disabled
				if (tick) begin
					next_count = countDown(count);
					next_preCnt = stepLength(shortNext, lsb);
					next_phase = shortNext ? 6'(phaseSum - {1'b0, msb}) : phaseSum[5:0];
					if (active && count == COUNT_ROLL_FROM) begin
						next_dogReset = 1'b1;
					end
				end else begin
					next_preCnt = preCnt - 16'h0001;
				end
				if (haltExec) begin
					if (cfg[CFG_IRQ_EN]) begin
						next_mode = MODE_ACTIVE_HALT;
						next_preCnt = preCnt;
						next_count = count;
					end else if (cfg[CFG_HALT_RST]) begin
						next_dogReset = 1'b1;
					end else begin
						// One last decrement that can no longer reset
						next_mode = MODE_HALT;
						next_count = countDown(count);
						next_dogReset = 1'b0;
					end
				end
			end
			MODE_ACTIVE_HALT: begin
				// Frozen; either interrupt restarts counting at once
				if (oscIrq || extIrq) begin
					next_mode = MODE_RUN;
				end
			end
			// Halt: only an external interrupt wakes
			MODE_HALT: begin
				if (extIrq) begin
					next_mode = MODE_WAKE_WAIT;
					next_wakeCnt = wakeLoad(cfg[CFG_WAKE_LONG]);
				end
			end
			MODE_WAKE_WAIT: begin
				// Oscillator settling time before counting again
				if (wakeCnt == 13'h0000) begin
					next_mode = MODE_RUN;
				end else begin
					next_wakeCnt = wakeCnt - 13'h0001;
				end
			end
		endcase
		// Software write: activation is sticky, counter reloads
		if (wrCtrl) begin
			next_actBit = actBit | wdata[ACT_BIT];
			next_count = wdata[6:0];
			next_phase = 6'h00;
			// Writing activation with top bit clear is a software reset
			if ((wdata[ACT_BIT] | hwOpt) && !wdata[TOP_BIT]) begin
				next_dogReset = 1'b1;
			end
		end
	end

	// Core registers; reset also ends any halt state
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			actBit <= DOG_CONTROL_RESET[ACT_BIT];
			count <= DOG_CONTROL_RESET[6:0];
			cfg <= DOG_CONFIG_RESET;
			preCnt <= 16'(STEP_CYCLES - 1);
			phase <= 6'h00;
			mode <= MODE_WAKE_WAIT;
			wakeCnt <= WAKE_SHORT - 13'h0001;
			dogReset <= 1'b0;
			hwOpt <= 1'b0;
			hwSeen <= 1'b0;
		end else begin
			actBit <= next_actBit;
			count <= next_count;
			cfg <= next_cfg;
			preCnt <= next_preCnt;
			phase <= next_phase;
			mode <= next_mode;
			wakeCnt <= next_wakeCnt;
			dogReset <= next_dogReset;
			hwOpt <= next_hwOpt;
			hwSeen <= next_hwSeen;
		end
	end

	// Mode output mirrors the state register
	assign dogMode = mode;

	// ***********************
	// APB slave
	// ***********************

	// Answer prepared in setup so pready stands in the first access cycle
	always_comb begin
		next_apbRsp.pready = apbReq.psel & ~apbReq.penable;
		next_apbRsp.pslverr = 1'b0;
		next_apbRsp.prdata = 32'h00000000;
		if (apbReq.psel && !apbReq.penable) begin
			unique case (apbReq.paddr)
				ADDR_DOG_CONTROL: begin
					next_apbRsp.prdata = {24'h000000, actBit, count};
				end
				ADDR_DOG_CONFIG: begin
					next_apbRsp.prdata = {27'h0000000, cfg};
				end
				ADDR_DOG_STATUS: begin
					next_apbRsp.prdata = {29'h00000000, hwOpt, mode};
				end
				default: begin
					next_apbRsp.pslverr = 1'b1;
				end
			endcase
		end
	end

	// Bus answer registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			apbRsp <= '0;
		end else begin
			apbRsp <= next_apbRsp;
		end
	end

endmodule

// ===== dv/wwdt_top_chk.sv
// Purpose: port assertions of the watchdog
// Assumes: one clock, synchronous reset
// Notes: bound into every wwdt_top
`timescale 1ns/1ps
module wwdt_top_chk
	import wwdt_pkg::*;
#(
	parameter int unsigned STEP_CYCLES = STEP_OSC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Bus and events
	input wire wwdt_pkg::wwdt_apb_req_t apbReq,
	input wire wwdt_pkg::wwdt_apb_rsp_t apbRsp,
	input wire logic extIrq,
	input wire logic oscIrq,
	// Outputs
	input wire logic dogReset,
	input wire logic [1:0] dogMode
);
	logic [12:0] waitLen;
	logic [12:0] next_waitLen;
	logic ctlWr;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Wake-wait length, saturating so a long stay cannot wrap
	always_comb next_waitLen = (sys_rst || dogMode != 2'd3) ? '0 : waitLen + {12'h0, ~&waitLen};
	always_ff @(posedge clk_sys) waitLen <= next_waitLen;
	// Completed write to the control word
	assign ctlWr = apbReq.psel & apbReq.penable & apbReq.pwrite & apbRsp.pready
		& (apbReq.paddr == ADDR_DOG_CONTROL);
	AST_RST_STATE: assert property (
		disable iff (1'b0) sys_rst |=> dogMode == 2'd3 && !dogReset) else $error("reset state");
	AST_SW_RESET: assert property (
		ctlWr && apbReq.pwdata[ACT_BIT] && !apbReq.pwdata[TOP_BIT] |=> dogReset)
		else $error("no software reset");
	AST_ZERO_WAIT: assert property (
		apbReq.psel && !apbReq.penable |=> apbRsp.pready) else $error("late ready");
	AST_ERR_ZERO: assert property (
		apbRsp.pslverr |-> apbRsp.pready && apbRsp.prdata == 32'h0) else $error("bad error");
	AST_AHALT_EXIT: assert property (
		dogMode == 2'd1 && (oscIrq || extIrq) |=> dogMode == 2'd0) else $error("no resume");
	AST_HALT_WAKE: assert property (
		dogMode == 2'd2 && extIrq |=> dogMode == 2'd3) else $error("no wake");
	AST_WAKE_LEN: assert property (
		dogMode == 2'd0 && $past(dogMode) == 2'd3 |-> waitLen >= 13'd255) else $error("short wait");
	AST_HALT_QUIET: assert property (
		dogMode == 2'd2 |-> !dogReset) else $error("reset in halt");
	// Main scenarios reached
	cover property (dogMode == 2'd1);
	cover property (dogReset);
	cover property (apbRsp.pslverr);
endmodule
bind wwdt_top wwdt_top_chk #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .apbReq(apbReq), .apbRsp(apbRsp), .extIrq(extIrq),
	.oscIrq(oscIrq), .dogReset(dogReset), .dogMode(dogMode));

// ===== dv/wwdt_rst_model.sv
// Purpose: system reset logic beside the watchdog
// Assumes: dogReset is a one-cycle request
// Notes: stretches it to a four-cycle reset
`timescale 1ns/1ps
module wwdt_rst_model (
	// Clock and bench reset
	input wire logic clk_sys,
	input wire logic benchRst,
	// Request in, reset out
	input wire logic dogReset,
	output logic rstReq
);
	logic [2:0] hold;
	// Stretch, as one cycle may be too short for the device
	always_ff @(posedge clk_sys) begin
		if (benchRst) hold <= 3'h0;
		else if (dogReset) hold <= 3'h4;
		else if (hold != 3'h0) hold <= hold - 3'h1;
	end
	assign rstReq = hold != 3'h0;
endmodule

// ===== dv/windowed_watchdog_timer_test.sv
// Purpose: self-checking bench of the watchdog
// Assumes: step shortened to 4160 cycles
// Notes: reads are checked against a queue
`timescale 1ns/1ps
module windowed_watchdog_timer_test;
	import wwdt_pkg::*;
	localparam int unsigned STEP = 4160;
	logic clk_sys, tbRst, rstReq, sys_rst, haltExec, extIrq, oscIrq, hwDogOption, dogReset;
	logic [1:0] dogMode;
	logic [7:0] v;
	logic [32:0] expQ [$];
	wwdt_apb_req_t apbReq;
	wwdt_apb_rsp_t apbRsp;
	int err_total = 0;
	int checks = 0;
	int pulses = 0;
	int n;
	assign sys_rst = tbRst | rstReq;
	wwdt_top #(.STEP_CYCLES(STEP)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .apbReq(apbReq),
		.apbRsp(apbRsp), .haltExec(haltExec), .extIrq(extIrq), .oscIrq(oscIrq),
		.hwDogOption(hwDogOption), .dogReset(dogReset), .dogMode(dogMode));
	wwdt_rst_model u_rst (.clk_sys(clk_sys), .benchRst(tbRst), .dogReset(dogReset),
		.rstReq(rstReq));
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string nm);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d checks %0d", err_total, checks);
		if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Setup, then hold until ready; idle edge after release
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		apbReq <= '{1'b1, 1'b0, w, a, {24'h0, d}};
		@(posedge clk_sys);
		apbReq.penable <= 1'b1;
		do @(posedge clk_sys); while (apbRsp.pready !== 1'b1);
		apbReq <= '0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic e);
		expQ.push_back({e, 24'h0, d});
		apb(1'b0, a, 8'h00);
	endtask
	task automatic ev(input logic [2:0] e);
		{haltExec, extIrq, oscIrq} <= e;
		@(posedge clk_sys);
		{haltExec, extIrq, oscIrq} <= 3'b000;
		@(posedge clk_sys);
	endtask
	task automatic wait_mode(input logic [1:0] m);
		n = 0;
		while (dogMode !== m && n < 6000) begin
			@(posedge clk_sys);
			n++;
		end
		chk(dogMode, m, "mode");
	endtask
	task automatic wait_pulse(input int k);
		repeat (3 * STEP) begin
			if (pulses == k) break;
			@(posedge clk_sys);
		end
		chk(pulses, k, "pulses");
		repeat (8) @(posedge clk_sys);
		wait_mode(2'd0);
	endtask
	// 125 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// Read results against the oldest note; count reset requests
	always @(posedge clk_sys) begin
		if (apbRsp.pready === 1'b1 && apbReq.pwrite === 1'b0 && expQ.size() > 0) begin
			chk({apbRsp.pslverr, apbRsp.prdata}, expQ.pop_front(), "read");
		end
		if (dogReset === 1'b1) pulses <= pulses + 1;
	end
	// Hang guard, far beyond the planned run
	initial begin
		#640000;
		err_total++;
		give_verdict();
	end
	// Main sequence
	initial begin
		apbReq = '0;
		{tbRst, haltExec, extIrq, oscIrq, hwDogOption} = 5'b10000;
		v = 8'($urandom(90));
		repeat (4) @(posedge clk_sys);
		tbRst <= 1'b0;
		wait_pulse(0);
		rd(ADDR_DOG_CONTROL, 8'h7f, 1'b0);
		rd(12'h004, 8'h00, 1'b1);
		wr_ctl(8'h40);
		repeat (2 * STEP) @(posedge clk_sys);
		chk(pulses, 0, "pulses");
		v = {2'b11, 6'($urandom)};
		wr_ctl(v);
		rd(ADDR_DOG_CONTROL, v, 1'b0);
		wr_ctl(8'h41);
		rd(ADDR_DOG_CONTROL, 8'hc1, 1'b0);
		wait_pulse(1);
		rd(ADDR_DOG_CONTROL, 8'h7f, 1'b0);
		wr_ctl(8'h80);
		wait_pulse(2);
		apb(1'b1, ADDR_DOG_CONFIG, 8'h08);
		ev(3'b100);
		wait_pulse(3);
		apb(1'b1, ADDR_DOG_CONFIG, 8'h04);
		for (int i = 0; i < 2; i++) begin
			ev(3'b100);
			chk(dogMode, 2'd1, "mode");
			ev(i ? 3'b010 : 3'b001);
			chk(dogMode, 2'd0, "mode");
		end
		apb(1'b1, ADDR_DOG_CONFIG, 8'h10);
		wr_ctl(8'hff);
		ev(3'b100);
		chk(dogMode, 2'd2, "mode");
		ev(3'b010);
		wait_mode(2'd0);
		chk(n >= 4000, 1'b1, "wake");
		chk(pulses, 3, "pulses");
		tbRst <= 1'b1;
		hwDogOption <= 1'b1;
		repeat (4) @(posedge clk_sys);
		tbRst <= 1'b0;
		wait_pulse(3);
		wr_ctl(8'h00);
		wait_pulse(4);
		give_verdict();
	end
	task automatic wr_ctl(input logic [7:0] d);
		apb(1'b1, ADDR_DOG_CONTROL, d);
	endtask
endmodule
